// ---- aisr_pkg.sv ----
// constants of the analog input and address switch readout
// assumes an object dictionary style access port (index, subindex) in front of it
package aisr_pkg;

  // object dictionary indices
  localparam logic [15:0] OD_IDX_ANALOG_VALUES = 16'h3220;
  localparam logic [15:0] OD_IDX_ANALOG_MODE = 16'h3221;
  localparam logic [15:0] OD_IDX_ADDR_SWITCH = 16'h3225;

  // subindices
  localparam logic [7:0] OD_SUB_COUNT = 8'h00;
  localparam logic [7:0] OD_SUB_FIRST = 8'h01;
  localparam logic [7:0] OD_SUB_SECOND = 8'h02;

  // entry contents and values after reset
  localparam logic [7:0] ANALOG_CHANNEL_COUNT = 8'h02;
  localparam logic [7:0] ADDRESS_SWITCH_COUNT = 8'h01;
  localparam logic [1:0] MODE_CONTROL_RESET = 2'h0;
  localparam logic [15:0] ANALOG_VALUE_RESET = 16'h0000;
  localparam logic [15:0] SWITCH_VALUE_RESET = 16'h0000;

  // field positions in the mode control word
  localparam int MODE_BIT_CH_ONE = 0;
  localparam int MODE_BIT_CH_TWO = 1;
  localparam int MODE_FIELD_WIDTH = 2;

  // digit scaling: full code against full scale
  localparam int ADC_FULL_SCALE_DIGITS = 1023;
  localparam int VOLTAGE_FULL_SCALE_V = 10;
  localparam int CURRENT_FULL_SCALE_MA = 20;

  // buffer geometry
  localparam int SAMPLE_BUFFER_DEPTH = 2;

  // address switch capture states
  typedef enum logic [0:0] {
    SW_ARMED = 1'b0,
    SW_HELD = 1'b1
  } aisr_sw_state_t;

endpackage

// ---- aisr_sample_buffer.sv ----
// two-entry sample buffer with valid and ready on both sides
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/1ns
module aisr_sample_buffer
  import aisr_pkg::*;
#(
  parameter int WIDTH = 17,
  parameter int DEPTH = SAMPLE_BUFFER_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic ready;
  } aisr_buf_state_t;

  aisr_buf_state_t s_q;
  aisr_buf_state_t s_d;
  logic push;
  logic pop;

  assign push = in_valid && s_q.ready;
  assign pop = out_ready && (s_q.count != '0);

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wr_ptr] = in_data;
      s_d.wr_ptr = (s_q.wr_ptr == LAST_PTR) ? '0 : s_q.wr_ptr + 1'b1;
    end
    if (pop) begin
      s_d.rd_ptr = (s_q.rd_ptr == LAST_PTR) ? '0 : s_q.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      s_d.count = s_q.count + 1'b1;
    end else if (pop && !push) begin
      s_d.count = s_q.count - 1'b1;
    end
    s_d.ready = (s_d.count != FULL_COUNT);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{mem: '0, wr_ptr: '0, rd_ptr: '0, count: '0, ready: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  assign in_ready = s_q.ready;
  assign out_valid = (s_q.count != '0);
  assign out_data = s_q.mem[s_q.rd_ptr];

endmodule

// ---- aisr_top.sv ----
// analog input and node address switch readout, seen through object dictionary entries
// assumes converter samples arrive as a valid/ready stream and switch pins are static
//
// Functional notes
// - each analog channel has a read-only entry with its latest raw converter digits.
// - a count entry reads two analog channels.
// - in voltage mode 1023 digits stand for 10 V.
// - in current mode, where fitted, 1023 digits stand for 20 mA.
// - a cleared mode bit selects voltage, a set bit selects current.
// - mode bit 0 belongs to analog channel one.
// - mode bit 1 belongs to analog channel two and the other bits do nothing.
// - current mode only takes hold on a channel whose hardware supports it.
// - the address switch is read once after restart and then held.
// - with one switch fitted its value sits in the switch entry at subindex 01.
// - with two switches fitted both are joined into the 16-bit entry at subindex 01.
`timescale 1ns/1ns
module aisr_top
  import aisr_pkg::*;
#(
  parameter logic [1:0] CURRENT_CAPABLE = 2'h3,
  parameter int SWITCHES_FITTED = 1,
  parameter int SWITCH_WIDTH = 8
) (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic [15:0] OD_INDEX,
  input wire logic [7:0] OD_SUB,
  input wire logic OD_RD,
  input wire logic OD_WR,
  input wire logic [31:0] OD_WDATA,
  output logic [31:0] OD_RDATA,
  output logic OD_ACK,
  output logic OD_ERR,
  input wire logic ADC_VALID,
  input wire logic ADC_CHAN,
  input wire logic [15:0] ADC_DATA,
  output logic ADC_READY,
  input wire logic [SWITCH_WIDTH-1:0] SW_ONE,
  input wire logic [SWITCH_WIDTH-1:0] SW_TWO,
  output logic [1:0] CH_CURRENT,
  output logic SW_CAPTURED
);

  localparam int NCH = 2;
  localparam int SAMPLE_W = 17;

  typedef struct packed {
    logic [MODE_FIELD_WIDTH-1:0] mode;
    logic [NCH-1:0][15:0] ch_val;
    logic [15:0] sw_val;
    aisr_sw_state_t sw_state;
    logic [NCH-1:0] cur_sel;
    logic [31:0] rdata;
    logic ack;
    logic err;
  } aisr_state_t;

  localparam aisr_state_t STATE_RESET = '{
    mode: MODE_CONTROL_RESET,
    ch_val: {NCH{ANALOG_VALUE_RESET}},
    sw_val: SWITCH_VALUE_RESET,
    sw_state: SW_ARMED,
    cur_sel: '0,
    rdata: 32'h00000000,
    ack: 1'b0,
    err: 1'b0
  };

  aisr_state_t s_q;
  aisr_state_t s_d;

  // sample stream through the buffer
  logic buf_out_valid;
  logic buf_out_ready;
  logic [SAMPLE_W-1:0] buf_out_data;
  logic [NCH-1:0] ch_update;
  logic [NCH-1:0] cur_eff;
  logic read_values;
  logic [15:0] sw_joined;

  aisr_sample_buffer #(
    .WIDTH(SAMPLE_W),
    .DEPTH(SAMPLE_BUFFER_DEPTH)
  ) u_buffer (
    .clk(CLK_SYS),
    .rst_n(NRST),
    .in_valid(ADC_VALID),
    .in_ready(ADC_READY),
    .in_data({ADC_CHAN, ADC_DATA}),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready),
    .out_data(buf_out_data)
  );

  // drain stalls while a read of the analog entries is taken, so the read sees settled values
  assign read_values = OD_RD && !OD_WR && (OD_INDEX == OD_IDX_ANALOG_VALUES);
  assign buf_out_ready = !read_values;

  // per-channel sample steering and mode gating
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_chan
      // a sample tagged with this channel number refreshes its entry
      assign ch_update[gi] = buf_out_valid && buf_out_ready &&
                             (buf_out_data[16] == 1'(gi));
      // current selection needs both the mode bit and hardware support
      assign cur_eff[gi] = s_q.mode[gi] && CURRENT_CAPABLE[gi];
    end
  endgenerate

  // one switch fills the low byte, two are joined with switch two on top
  generate
    if (SWITCHES_FITTED >= 2) begin : g_two_sw
      assign sw_joined = {SW_TWO[7:0], SW_ONE[7:0]};
    end else begin : g_one_sw
      assign sw_joined = {8'h00, SW_ONE[7:0]};
    end
  endgenerate

  always_comb begin
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.err = 1'b0;

    // analog values follow the converter
    for (int i = 0; i < NCH; i++) begin
      if (ch_update[i]) begin
        s_d.ch_val[i] = buf_out_data[15:0];
      end
    end

    // the mode output follows the stored control word masked by CURRENT_CAPABLE
    s_d.cur_sel = cur_eff;

    // switch capture once after restart
    unique case (s_q.sw_state)
      SW_ARMED: begin
        s_d.sw_val = sw_joined;
        s_d.sw_state = SW_HELD;
      end
      SW_HELD: begin
        s_d.sw_val = s_q.sw_val;
      end
    endcase

    // object dictionary writes
    if (OD_WR) begin
      s_d.ack = 1'b1;
      s_d.rdata = 32'h00000000;
      if (OD_INDEX == OD_IDX_ANALOG_MODE && OD_SUB == OD_SUB_COUNT) begin
        s_d.mode[MODE_BIT_CH_ONE] = OD_WDATA[MODE_BIT_CH_ONE];
        s_d.mode[MODE_BIT_CH_TWO] = OD_WDATA[MODE_BIT_CH_TWO];
      end else begin
        s_d.err = 1'b1;
      end
    end else if (OD_RD) begin
      // object dictionary reads
      s_d.ack = 1'b1;
      s_d.rdata = 32'h00000000;
      unique case (OD_INDEX)
        OD_IDX_ANALOG_VALUES: begin
          if (OD_SUB == OD_SUB_COUNT) begin
            s_d.rdata = {24'h000000, ANALOG_CHANNEL_COUNT};
          end else if (OD_SUB == OD_SUB_FIRST) begin
            // digits read raw; 1023 is 10 V or 20 mA by the channel's mode
            s_d.rdata = {{16{s_q.ch_val[0][15]}}, s_q.ch_val[0]};
          end else if (OD_SUB == OD_SUB_SECOND) begin
            s_d.rdata = {{16{s_q.ch_val[1][15]}}, s_q.ch_val[1]};
          end else begin
            s_d.err = 1'b1;
          end
        end
        OD_IDX_ANALOG_MODE: begin
          if (OD_SUB == OD_SUB_COUNT) begin
            s_d.rdata = {30'h00000000, s_q.mode};
          end else begin
            s_d.err = 1'b1;
          end
        end
        OD_IDX_ADDR_SWITCH: begin
          if (OD_SUB == OD_SUB_COUNT) begin
            s_d.rdata = {24'h000000, ADDRESS_SWITCH_COUNT};
          end else if (OD_SUB == OD_SUB_FIRST) begin
            s_d.rdata = {16'h0000, s_q.sw_val};
          end else begin
            s_d.err = 1'b1;
          end
        end
        default: begin
          s_d.err = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      s_q <= STATE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign OD_RDATA = s_q.rdata;
  assign OD_ACK = s_q.ack;
  assign OD_ERR = s_q.err;
  assign CH_CURRENT = s_q.cur_sel;
  assign SW_CAPTURED = (s_q.sw_state == SW_HELD);

endmodule

// ---- aisr_props.sv ----
// assertions on the readout's access port and mode outputs
// assumes it is bound into aisr_top
`timescale 1ns/1ns
module aisr_props #(
  parameter logic [1:0] CURRENT_CAPABLE = 2'h3
) (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic [15:0] OD_INDEX,
  input wire logic [7:0] OD_SUB,
  input wire logic OD_RD,
  input wire logic OD_WR,
  input wire logic [31:0] OD_WDATA,
  input wire logic [31:0] OD_RDATA,
  input wire logic OD_ACK,
  input wire logic OD_ERR,
  input wire logic [1:0] CH_CURRENT,
  input wire logic SW_CAPTURED
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  wire logic rq = OD_RD | OD_WR;
  wire logic rd0 = OD_RD && !OD_WR && OD_SUB == 8'h00;
  a_req_gets_ack: assert property (rq |=> OD_ACK) else $error("ack missing");
  a_ack_needs_req: assert property (OD_ACK |-> $past(rq)) else $error("stray ack");
  a_value_read_only: assert property (OD_WR && OD_INDEX == 16'h3220 |=> OD_ERR) else $error("value written");
  a_count_two: assert property (rd0 && OD_INDEX == 16'h3220 |=>
    OD_RDATA == 32'h2 && !OD_ERR) else $error("count");
  a_mode_gated: assert property (OD_WR && OD_INDEX == 16'h3221 && OD_SUB == 8'h00 |->
    ##2 CH_CURRENT == (2'($past(OD_WDATA, 2)) & CURRENT_CAPABLE)) else $error("mode output");
  a_mode_upper_zero: assert property (rd0 && OD_INDEX == 16'h3221 |=>
    OD_RDATA[31:2] == 30'h0) else $error("mode");
  a_reset_voltage: assert property (!$past(NRST) |-> CH_CURRENT == 2'h0) else $error("mode reset");
  a_switch_held: assert property ($past(NRST) |-> SW_CAPTURED) else $error("switch capture");
  a_switch_one_entry: assert property (rd0 && OD_INDEX == 16'h3225 |=>
    OD_RDATA == 32'h1) else $error("sw count");
endmodule
bind aisr_top aisr_props #(.CURRENT_CAPABLE(CURRENT_CAPABLE)) aisr_props_inst (.CLK_SYS(CLK_SYS), .NRST(NRST),
  .OD_INDEX(OD_INDEX), .OD_SUB(OD_SUB), .OD_RD(OD_RD), .OD_WR(OD_WR), .OD_WDATA(OD_WDATA), .OD_RDATA(OD_RDATA),
  .OD_ACK(OD_ACK), .OD_ERR(OD_ERR), .CH_CURRENT(CH_CURRENT), .SW_CAPTURED(SW_CAPTURED));

// ---- aisr_adc_src.sv ----
// converter stream and rotary switch pins facing the readout
// assumes the bench calls send and sets switch positions
`timescale 1ns/1ns
module aisr_adc_src (
  input wire logic clk,
  input wire logic ready,
  output logic valid,
  output logic chan,
  output logic [15:0] data,
  output logic [7:0] sw_one,
  output logic [7:0] sw_two
);
  initial begin
    valid = 1'b0;
    chan = 1'b0;
    data = 16'h0000;
    sw_one = 8'h5A;
    sw_two = 8'hC3;
  end
  // sample held until taken, then data lines lose their value
  task automatic send(input logic c, input logic [15:0] d);
    @(posedge clk);
    valid <= 1'b1;
    chan <= c;
    data <= d;
    @(posedge clk);
    while (!ready) @(posedge clk);
    valid <= 1'b0;
    data <= ~d;
  endtask
endmodule

// ---- tb.sv ----
// self-checking bench for the analog input and switch readout
// assumes two switches fitted and current mode on channel one only; a second instance has one switch and current on both
`timescale 1ns/1ns
module tb;
  import aisr_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [15:0] idx = 16'h0000;
  logic [7:0] sub = 8'h00;
  logic rdr = 1'b0;
  logic wrr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata, rd, rdata_one;
  logic ack, err, er, av, ach, ardy, capd;
  logic [15:0] ad;
  logic [7:0] s1, s2;
  logic [1:0] cur;
  int bad_count = 0;
  int total_checks = 0;
  initial begin
    forever #50 clk = ~clk;
  end
  aisr_top #(.CURRENT_CAPABLE(2'h1), .SWITCHES_FITTED(2), .SWITCH_WIDTH(8)) aisr_top_inst (.CLK_SYS(clk),
    .NRST(nrst), .OD_INDEX(idx), .OD_SUB(sub), .OD_RD(rdr), .OD_WR(wrr), .OD_WDATA(wd), .OD_RDATA(rdata),
    .OD_ACK(ack), .OD_ERR(err), .ADC_VALID(av), .ADC_CHAN(ach), .ADC_DATA(ad), .ADC_READY(ardy),
    .SW_ONE(s1), .SW_TWO(s2), .CH_CURRENT(cur), .SW_CAPTURED(capd));
  aisr_top #(.CURRENT_CAPABLE(2'h3), .SWITCHES_FITTED(1), .SWITCH_WIDTH(8)) aisr_top_inst_one (.CLK_SYS(clk),
    .NRST(nrst), .OD_INDEX(idx), .OD_SUB(sub), .OD_RD(rdr), .OD_WR(wrr), .OD_WDATA(wd), .OD_RDATA(rdata_one),
    .OD_ACK(), .OD_ERR(), .ADC_VALID(av), .ADC_CHAN(ach), .ADC_DATA(ad), .ADC_READY(),
    .SW_ONE(s1), .SW_TWO(s2), .CH_CURRENT(), .SW_CAPTURED());
  aisr_adc_src aisr_adc_src_inst (.clk(clk), .ready(ardy), .valid(av), .chan(ach), .data(ad), .sw_one(s1),
    .sw_two(s2));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic od(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d);
    @(posedge clk);
    wrr <= w;
    rdr <= ~w;
    idx <= i;
    sub <= s;
    wd <= d;
    @(posedge clk);
    wrr <= 1'b0;
    rdr <= 1'b0;
    #1;
    rd = rdata;
    er = err;
    chk("ack", 32'h1, {31'h0, ack});
  endtask
  task automatic t_after_reset();
    od(0, OD_IDX_ANALOG_VALUES, OD_SUB_COUNT, 0);
    chk("count", 32'h2, rd);
    od(0, OD_IDX_ANALOG_MODE, OD_SUB_COUNT, 0);
    chk("mode", 32'h0, rd);
    od(0, OD_IDX_ADDR_SWITCH, OD_SUB_COUNT, 0);
    chk("sw count", 32'h1, rd);
    od(0, OD_IDX_ADDR_SWITCH, OD_SUB_FIRST, 0);
    chk("sw value", 32'hC35A, rd);
    chk("sw single", 32'h005A, rdata_one);
    od(1, OD_IDX_ANALOG_VALUES, OD_SUB_FIRST, 32'h5);
    chk("value write", 32'h1, {31'h0, er});
    od(0, 16'h3222, OD_SUB_COUNT, 0);
    chk("unmapped", 32'h1, {31'h0, er});
  endtask
  task automatic t_switch_hold();
    @(posedge clk);
    aisr_adc_src_inst.sw_one <= 8'h11;
    aisr_adc_src_inst.sw_two <= 8'h22;
    od(0, OD_IDX_ADDR_SWITCH, OD_SUB_FIRST, 0);
    chk("sw held", 32'hC35A, rd);
  endtask
  task automatic t_mode();
    for (int v = 0; v < 4; v++) begin
      od(1, OD_IDX_ANALOG_MODE, OD_SUB_COUNT, 32'hFFFF_FFF0 | 32'(v));
      @(posedge clk);
      #1;
      chk("current", 32'(v) & 32'h1, {30'h0, cur});
      od(0, OD_IDX_ANALOG_MODE, OD_SUB_COUNT, 0);
      chk("mode back", 32'(v), rd);
    end
  endtask
  task automatic t_stream();
    logic full = 1'b0;
    fork
      begin
        aisr_adc_src_inst.send(1'b0, 16'h0200);
        aisr_adc_src_inst.send(1'b1, 16'hFC01);
        aisr_adc_src_inst.send(1'b0, 16'h03FF);
      end
      begin
        @(posedge clk);
        rdr <= 1'b1;
        idx <= OD_IDX_ANALOG_VALUES;
        sub <= OD_SUB_FIRST;
        repeat (8) begin
          @(posedge clk);
          #1;
          if (!ardy) full = 1'b1;
        end
        @(posedge clk);
        rdr <= 1'b0;
      end
    join
    repeat (3) @(posedge clk);
    chk("stall", 32'h1, {31'h0, full});
    od(0, OD_IDX_ANALOG_VALUES, OD_SUB_FIRST, 0);
    chk("chan one", 32'h0000_03FF, rd);
    od(0, OD_IDX_ANALOG_VALUES, OD_SUB_SECOND, 0);
    chk("chan two", 32'hFFFF_FC01, rd);
  endtask
  task automatic t_restart();
    @(posedge clk);
    nrst <= 1'b0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    od(0, OD_IDX_ADDR_SWITCH, OD_SUB_FIRST, 0);
    chk("sw new", 32'h2211, rd);
    chk("current rst", 32'h0, {30'h0, cur});
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_after_reset();
    t_switch_hold();
    t_mode();
    t_stream();
    t_restart();
    tally_and_finish();
  end
  initial begin
    #100000;
    bad_count++;
    tally_and_finish();
  end
endmodule
